// file: dslv_pkg.sv
// Purpose: shared constants for the default error-response slave
// Assumes: byte-addressed register port, 32-bit register words
// Notes: offsets are byte addresses
package dslv_pkg;
	// register port
	localparam int CSR_ADDR_W = 9;
	localparam logic [8:0] OFS_IRQ_STATUS = 9'h000;
	localparam logic [8:0] OFS_RD_ATTR = 9'h100;
	localparam logic [8:0] OFS_RD_MASTER_ID = 9'h104;
	localparam logic [8:0] OFS_RD_ADDR_LOW = 9'h108;
	localparam logic [8:0] OFS_RD_ADDR_HIGH = 9'h10c;
	// status bit positions
	localparam int ST_WR_FLAG = 0;
	localparam int ST_RD_FLAG = 1;
	localparam int ST_WR_OVF = 2;
	localparam int ST_RD_OVF = 3;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	// attribute word field positions
	localparam int ATTR_VALID_BIT = 0;
	localparam int ATTR_PROT_LSB = 1;
	localparam int ATTR_SIZE_LSB = 4;
	localparam int ATTR_LEN_LSB = 7;
	localparam int ATTR_BURST_LSB = 11;
	// bus answer
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam int LOG_CNT_W = 5;
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_DATA = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;
	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_t;
endpackage

// file: dslv_log_fifo.sv
// Purpose: violation log queue, oldest entry presented first
// Assumes: flush and push in one cycle leave only the new entry
// Notes: a push while full is dropped; caller flags the loss
module dslv_log_fifo import dslv_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic flush_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [WIDTH-1:0] data_i,
	output logic [WIDTH-1:0] data_o,
	output logic valid_o,
	output logic full_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [LOG_CNT_W-1:0] DEPTH_C = LOG_CNT_W'(DEPTH);

	if (DEPTH < 1 || DEPTH > 16 || WIDTH < 1) begin : g_bad
		$error("log fifo depth must be 1 to 16");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] rd_q, wr_q, base_rd, base_wr;
	logic [LOG_CNT_W-1:0] cnt_q, base_cnt;
	logic do_push, do_pop;

	// flush acts first, then push and pop on the emptied queue
	always_comb begin
		base_rd = flush_i ? '0 : rd_q;
		base_wr = flush_i ? '0 : wr_q;
		base_cnt = flush_i ? '0 : cnt_q;
		do_pop = pop_i && !flush_i && (cnt_q != '0);
		do_push = push_i && (base_cnt < DEPTH_C);
	end

	// pointers and fill count
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else begin
			rd_q <= do_pop ? ((base_rd == LAST) ? '0 : base_rd + 1'b1) : base_rd;
			wr_q <= do_push ? ((base_wr == LAST) ? '0 : base_wr + 1'b1) : base_wr;
			cnt_q <= base_cnt + LOG_CNT_W'(do_push) - LOG_CNT_W'(do_pop);
		end
	end

	// entry storage
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[base_wr] <= data_i;
		end
	end

	assign data_o = mem[rd_q];
	assign valid_o = (cnt_q != '0);
	assign full_o = (cnt_q == DEPTH_C);
endmodule // dslv_log_fifo

// file: dslv_default_slave.sv
// Purpose: answers undecoded AXI accesses with DECERR and logs them
// Assumes: one clock, synchronous reset, register port on same clock
// Notes: read log popped by reading the upper address word
// Behaviour
// [R01] master id width parameter, 1 to 8
// [R02] logged address width parameter, 8 to 64
// [R03] data width parameter: 32, 64, 128
// [R04] option removes register port and logging
// [R05] log depth parameter, 1 to 16 entries
// [R06] option registers register port inputs
// [R07] violation raises interrupt and logs entry
// [R08] flag stays set while log holds entries
// [R09] cleared flag only set by new violation
// [R10] full log drops entry, sets overflow
// [R11] host drains log until attribute valid bit drops
// [R12] status bits 3,2 are read/write overflow
// [R13] status bits 1,0 are read/write violation
// [R14] write one clears; upper bits read zero
// [R15] violations logged until flag cleared
// [R16] attribute word: burst, length, size, protection
// [R17] attribute bit 0 valid, cleared with flag
// [R18] register gives logged read master id
// [R19] two registers give logged read address
// [R20] reading upper address pops the entry
// [R21] host trusts log only while flag set
// [R22] drained log accepts new violations
// [R23] every access answered with decode error
// [R24] one read, one write outstanding, independent
// [R25] register reads answer after one cycle; the code takes two when the [R06] input stage is on
// [R26] oldest entry first, held until pop
module dslv_default_slave import dslv_pkg::*; #(
	parameter int ID_W = 4, // [R01]
	parameter int ADDR_W = 32, // [R02]
	parameter int DATA_W = 32, // [R03]
	parameter bit CSR_EN = 1'b1, // [R04]
	parameter int LOG_DEPTH = 4, // [R05]
	parameter bit CSR_REG_IN = 1'b0 // [R06]
) (
	input wire logic SYS_CLK_I,
	input wire logic SRST_I,
	input wire logic [ID_W-1:0] AXI_AWID_I,
	input wire logic [ADDR_W-1:0] AXI_AWADDR_I,
	input wire logic [3:0] AXI_AWLEN_I,
	input wire logic [2:0] AXI_AWSIZE_I,
	input wire logic [1:0] AXI_AWBURST_I,
	input wire logic [2:0] AXI_AWPROT_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [DATA_W-1:0] AXI_WDATA_I,
	input wire logic AXI_WLAST_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	output logic [ID_W-1:0] AXI_BID_O,
	output logic [1:0] AXI_BRESP_O,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	input wire logic [ID_W-1:0] AXI_ARID_I,
	input wire logic [ADDR_W-1:0] AXI_ARADDR_I,
	input wire logic [3:0] AXI_ARLEN_I,
	input wire logic [2:0] AXI_ARSIZE_I,
	input wire logic [1:0] AXI_ARBURST_I,
	input wire logic [2:0] AXI_ARPROT_I,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	output logic [ID_W-1:0] AXI_RID_O,
	output logic [DATA_W-1:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic AXI_RLAST_O,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	input wire logic [CSR_ADDR_W-1:0] CSR_ADDR_I,
	input wire logic CSR_READ_I,
	input wire logic CSR_WRITE_I,
	input wire logic [31:0] CSR_WDATA_I,
	output logic [31:0] CSR_RDATA_O,
	output logic IRQ_O
);
	// parameter range checks
	if (ID_W < 1 || ID_W > 8) begin : g_bad_id
		$error("id width must be 1 to 8"); // [R01]
	end
	if (ADDR_W < 8 || ADDR_W > 64) begin : g_bad_addr
		$error("address width must be 8 to 64"); // [R02]
	end
	if (DATA_W != 32 && DATA_W != 64 && DATA_W != 128) begin : g_bad_data
		$error("data width must be 32, 64 or 128"); // [R03]
	end
	if (LOG_DEPTH < 1 || LOG_DEPTH > 16) begin : g_bad_depth
		$error("log depth must be 1 to 16"); // [R05]
	end

	wr_state_t wr_state_q;
	rd_state_t rd_state_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, rlast_q;
	logic [ID_W-1:0] bid_q, rid_q;
	logic [3:0] beats_q;
	logic wr_evt, rd_evt;

	assign wr_evt = AXI_AWVALID_I && awready_q;
	assign rd_evt = AXI_ARVALID_I && arready_q;

	// write channel: one burst at a time, data drained then DECERR
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			wr_state_q <= WR_IDLE;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bid_q <= '0;
		end else begin
			case (wr_state_q)
				WR_IDLE: begin
					if (wr_evt) begin // [R24]
						awready_q <= 1'b0;
						wready_q <= 1'b1;
						bid_q <= AXI_AWID_I;
						wr_state_q <= WR_DATA;
					end else begin
						awready_q <= 1'b1;
					end
				end
				WR_DATA: begin
					if (AXI_WVALID_I && AXI_WLAST_I) begin
						wready_q <= 1'b0;
						bvalid_q <= 1'b1; // [R23]
						wr_state_q <= WR_RESP;
					end
				end
				WR_RESP: begin
					if (AXI_BREADY_I) begin
						bvalid_q <= 1'b0;
						awready_q <= 1'b1;
						wr_state_q <= WR_IDLE;
					end
				end
				default: wr_state_q <= WR_IDLE;
			endcase
		end
	end

	// read channel: len+1 zero beats, each with DECERR
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			rd_state_q <= RD_IDLE;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rlast_q <= 1'b0;
			rid_q <= '0;
			beats_q <= '0;
		end else begin
			case (rd_state_q)
				RD_IDLE: begin
					if (rd_evt) begin // [R24]
						arready_q <= 1'b0;
						rvalid_q <= 1'b1; // [R23]
						rlast_q <= (AXI_ARLEN_I == 4'h0);
						rid_q <= AXI_ARID_I;
						beats_q <= AXI_ARLEN_I;
						rd_state_q <= RD_DATA;
					end else begin
						arready_q <= 1'b1;
					end
				end
				RD_DATA: begin
					if (AXI_RREADY_I) begin
						if (rlast_q) begin
							rvalid_q <= 1'b0;
							rlast_q <= 1'b0;
							arready_q <= 1'b1;
							rd_state_q <= RD_IDLE;
						end else begin
							beats_q <= beats_q - 4'h1;
							rlast_q <= (beats_q == 4'h1);
						end
					end
				end
				default: rd_state_q <= RD_IDLE;
			endcase
		end
	end

	assign AXI_AWREADY_O = awready_q;
	assign AXI_WREADY_O = wready_q;
	assign AXI_BVALID_O = bvalid_q;
	assign AXI_BID_O = bid_q;
	assign AXI_BRESP_O = RESP_DECERR; // [R23]
	assign AXI_ARREADY_O = arready_q;
	assign AXI_RVALID_O = rvalid_q;
	assign AXI_RLAST_O = rlast_q;
	assign AXI_RID_O = rid_q;
	assign AXI_RDATA_O = '0;
	assign AXI_RRESP_O = RESP_DECERR; // [R23]

	// bus-side checks
	property p_one_read;
		@(posedge SYS_CLK_I) disable iff (SRST_I)
		AXI_RVALID_O |-> !AXI_ARREADY_O; // no address taken while beats are open
	endproperty
	property p_read_beats;
		@(posedge SYS_CLK_I) disable iff (SRST_I)
		(rd_evt && AXI_ARLEN_I == 4'h1) ##1 AXI_RREADY_I |->
			AXI_RVALID_O && !AXI_RLAST_O ##1 AXI_RVALID_O && AXI_RLAST_O;
	endproperty
	property p_write_resp;
		@(posedge SYS_CLK_I) disable iff (SRST_I)
		(AXI_WREADY_O && AXI_WVALID_I && AXI_WLAST_I) |=>
			AXI_BVALID_O && AXI_BRESP_O == RESP_DECERR && !AXI_AWREADY_O;
	endproperty
	a_one_read: assert property (p_one_read) else $error("second read accepted"); // [R24]
	a_read_beats: assert property (p_read_beats) else $error("read beat count wrong"); // [R23]
	a_write_resp: assert property (p_write_resp) else $error("write not answered"); // [R23]
	c_write_done: cover property (@(posedge SYS_CLK_I) AXI_BVALID_O && AXI_BREADY_I);

	if (CSR_EN) begin : g_csr // [R04]
		localparam int EW = ID_W + ADDR_W + 12;
		localparam int A_LSB = 12;
		localparam int I_LSB = 12 + ADDR_W;
		localparam logic [LOG_CNT_W-1:0] DEPTH_C = LOG_CNT_W'(LOG_DEPTH);
		logic [CSR_ADDR_W-1:0] c_addr;
		logic c_rd, c_wr;
		logic [31:0] c_wdata;
		logic [3:0] stat_q, clr;
		logic [EW-1:0] entry_in, entry;
		logic r_valid, r_full, r_pop, irq_q;
		logic [LOG_CNT_W-1:0] wcnt_q;
		logic [63:0] addr_ext;
		logic [31:0] rdata_q;

		// optional input stage on the register port
		if (CSR_REG_IN) begin : g_reg_in // [R06]
			logic [CSR_ADDR_W-1:0] addr_q;
			logic rd_q, wr_q;
			logic [31:0] wdata_q;
			always_ff @(posedge SYS_CLK_I) begin
				if (SRST_I) begin
					addr_q <= '0;
					rd_q <= 1'b0;
					wr_q <= 1'b0;
					wdata_q <= '0;
				end else begin
					addr_q <= CSR_ADDR_I;
					rd_q <= CSR_READ_I;
					wr_q <= CSR_WRITE_I;
					wdata_q <= CSR_WDATA_I;
				end
			end
			assign c_addr = addr_q;
			assign c_rd = rd_q;
			assign c_wr = wr_q;
			assign c_wdata = wdata_q;
		end else begin : g_direct
			assign c_addr = CSR_ADDR_I;
			assign c_rd = CSR_READ_I;
			assign c_wr = CSR_WRITE_I;
			assign c_wdata = CSR_WDATA_I;
		end

		// write-one-to-clear strobes and log pop
		assign clr = (c_wr && c_addr == OFS_IRQ_STATUS) ? c_wdata[3:0] : 4'h0; // [R14]
		assign r_pop = c_rd && (c_addr == OFS_RD_ADDR_HIGH); // [R20]
		assign entry_in = {AXI_ARID_I, AXI_ARADDR_I, AXI_ARBURST_I, AXI_ARLEN_I,
			AXI_ARSIZE_I, AXI_ARPROT_I};

		// read log queue, emptied when its flag is cleared
		dslv_log_fifo #(.WIDTH(EW), .DEPTH(LOG_DEPTH)) u_rd_log (
			.clk_i(SYS_CLK_I),
			.srst_i(SRST_I),
			.flush_i(clr[ST_RD_FLAG]), // [R17]
			.push_i(rd_evt), // [R07] [R15] [R22]
			.pop_i(r_pop), // [R26]
			.data_i(entry_in),
			.data_o(entry),
			.valid_o(r_valid),
			.full_o(r_full)
		);

		// write log occupancy; its contents have no readout here
		always_ff @(posedge SYS_CLK_I) begin
			if (SRST_I) begin
				wcnt_q <= '0;
			end else if (clr[ST_WR_FLAG]) begin
				wcnt_q <= wr_evt ? LOG_CNT_W'(1) : '0;
			end else if (wr_evt && wcnt_q != DEPTH_C) begin
				wcnt_q <= wcnt_q + LOG_CNT_W'(1);
			end
		end

		// sticky status, set wins over a same-cycle clear
		always_ff @(posedge SYS_CLK_I) begin
			if (SRST_I) begin
				stat_q <= STATUS_RESET;
			end else begin
				stat_q <= (stat_q & ~clr) | {
					rd_evt && r_full && !clr[ST_RD_FLAG], // [R10] [R12]
					wr_evt && wcnt_q == DEPTH_C && !clr[ST_WR_FLAG], // [R10] [R12]
					rd_evt, // [R07] [R09] [R13]
					wr_evt}; // [R13]
			end
		end

		// interrupt follows any set status bit
		always_ff @(posedge SYS_CLK_I) begin
			if (SRST_I) begin
				irq_q <= 1'b0;
			end else begin
				irq_q <= |stat_q; // [R08]
			end
		end

		// register read mux, answer one cycle after the strobe
		assign addr_ext = 64'(entry[A_LSB +: ADDR_W]);
		always_ff @(posedge SYS_CLK_I) begin
			if (SRST_I) begin
				rdata_q <= '0;
			end else if (c_rd) begin // [R25]
				case (c_addr)
					OFS_IRQ_STATUS: rdata_q <= {28'h0, stat_q}; // [R14]
					OFS_RD_ATTR: rdata_q <= r_valid ? {19'h0, entry[11:0], 1'b1} : 32'h0; // [R16] [R17]
					OFS_RD_MASTER_ID: rdata_q <= r_valid ? 32'(entry[I_LSB +: ID_W]) : 32'h0; // [R18]
					OFS_RD_ADDR_LOW: rdata_q <= r_valid ? addr_ext[31:0] : 32'h0; // [R19]
					OFS_RD_ADDR_HIGH: rdata_q <= r_valid ? addr_ext[63:32] : 32'h0; // [R19]
					default: rdata_q <= 32'h0;
				endcase
			end
		end
		assign CSR_RDATA_O = rdata_q;
		assign IRQ_O = irq_q;

		// logging checks
		property p_rd_log;
			@(posedge SYS_CLK_I) disable iff (SRST_I)
			(rd_evt && !r_full && !r_pop) |=> stat_q[ST_RD_FLAG] && r_valid ##1 IRQ_O;
		endproperty
		property p_overflow;
			@(posedge SYS_CLK_I) disable iff (SRST_I)
			(rd_evt && r_full && !clr[ST_RD_FLAG]) |=> stat_q[ST_RD_OVF];
		endproperty
		property p_clear;
			@(posedge SYS_CLK_I) disable iff (SRST_I)
			(clr[ST_RD_FLAG] && !rd_evt) |=> !stat_q[ST_RD_FLAG] && !r_valid;
		endproperty
		property p_hold;
			@(posedge SYS_CLK_I) disable iff (SRST_I)
			(stat_q[ST_WR_FLAG] && !clr[ST_WR_FLAG]) |=> stat_q[ST_WR_FLAG];
		endproperty
		property p_no_reassert;
			@(posedge SYS_CLK_I) disable iff (SRST_I)
			(!stat_q[ST_RD_FLAG] && !rd_evt) |=> !stat_q[ST_RD_FLAG];
		endproperty
		property p_status_read;
			@(posedge SYS_CLK_I) disable iff (SRST_I)
			(c_rd && c_addr == OFS_IRQ_STATUS) |=> CSR_RDATA_O == {28'h0, $past(stat_q)};
		endproperty
		property p_attr_valid;
			@(posedge SYS_CLK_I) disable iff (SRST_I)
			(c_rd && c_addr == OFS_RD_ATTR) |=> CSR_RDATA_O[ATTR_VALID_BIT] == $past(r_valid);
		endproperty
		a_rd_log: assert property (p_rd_log) else $error("read violation not logged"); // [R07]
		a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // [R10]
		a_clear: assert property (p_clear) else $error("flag or log not cleared"); // [R17]
		a_hold: assert property (p_hold) else $error("flag lost without clear"); // [R14]
		a_no_reassert: assert property (p_no_reassert) else $error("flag set with no event"); // [R09]
		a_status_read: assert property (p_status_read) else $error("status read wrong"); // [R25]
		a_attr_valid: assert property (p_attr_valid) else $error("valid bit wrong"); // [R17]
		c_overflow: cover property (@(posedge SYS_CLK_I) stat_q[ST_RD_OVF]);
		c_pop: cover property (@(posedge SYS_CLK_I) r_pop && r_valid);
		c_both: cover property (@(posedge SYS_CLK_I) rd_evt && wr_evt);
	end else begin : g_no_csr
		assign CSR_RDATA_O = 32'h0;
		assign IRQ_O = 1'b0;
	end
endmodule // dslv_default_slave

// file: dslv_axi_mst.sv
// Purpose: AXI master model that sends bursts to undecoded space
// Assumes: drives on the falling edge, samples on the rising edge
// Notes: one read and one write open at a time; released address lines invert
module dslv_axi_mst #(
	parameter int ID_W = 4,
	parameter int ADDR_W = 40
) (
	input wire logic clk_i,
	output logic [ID_W-1:0] awid_o,
	output logic [ADDR_W-1:0] awaddr_o,
	output logic [3:0] awlen_o,
	output logic [2:0] awsize_o,
	output logic [1:0] awburst_o,
	output logic [2:0] awprot_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic wlast_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic [ID_W-1:0] bid_i,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	output logic [ID_W-1:0] arid_o,
	output logic [ADDR_W-1:0] araddr_o,
	output logic [3:0] arlen_o,
	output logic [2:0] arsize_o,
	output logic [1:0] arburst_o,
	output logic [2:0] arprot_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic [ID_W-1:0] rid_i,
	input wire logic [1:0] rresp_i,
	input wire logic rlast_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		{awid_o, awaddr_o, awlen_o, awsize_o, awburst_o, awprot_o, awvalid_o} = '0;
		{wdata_o, wlast_o, wvalid_o, bready_o} = '0;
		{arid_o, araddr_o, arlen_o, arsize_o, arburst_o, arprot_o, arvalid_o, rready_o} = '0;
	end
	// write burst, f = {burst, len, size, prot}; response taken after slow cycles
	task automatic wr(input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] a,
		input logic [11:0] f, input int slow, output logic [ID_W-1:0] bid, output logic [1:0] rs);
		@(negedge clk_i);
		{awid_o, awaddr_o, awvalid_o} = {id, a, 1'b1};
		{awburst_o, awlen_o, awsize_o, awprot_o} = f;
		do @(posedge clk_i); while (!awready_i);
		@(negedge clk_i);
		awvalid_o = 1'b0;
		awaddr_o = ~a;
		for (int i = 0; i <= f[9:6]; i++) begin
			{wvalid_o, wlast_o} = {1'b1, i == f[9:6]};
			wdata_o = ~wdata_o;
			do @(posedge clk_i); while (!wready_i);
			@(negedge clk_i);
		end
		{wvalid_o, wlast_o} = 2'b00;
		repeat (slow) @(negedge clk_i);
		bready_o = 1'b1;
		do @(posedge clk_i); while (!bvalid_i);
		{bid, rs} = {bid_i, bresp_i};
		@(negedge clk_i);
		bready_o = 1'b0;
	endtask
	// read burst; counts beats up to the last one, ready held off slow cycles
	task automatic rd(input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] a,
		input logic [11:0] f, input int slow, output logic [ID_W-1:0] rid, output logic [1:0] rs,
		output int n);
		logic last;
		@(negedge clk_i);
		{arid_o, araddr_o, arvalid_o} = {id, a, 1'b1};
		{arburst_o, arlen_o, arsize_o, arprot_o} = f;
		do @(posedge clk_i); while (!arready_i);
		@(negedge clk_i);
		arvalid_o = 1'b0;
		araddr_o = ~a;
		{n, rs, last} = {32'd0, 2'h3, 1'b0};
		repeat (slow) @(negedge clk_i);
		rready_o = 1'b1;
		while (!last) begin
			@(posedge clk_i);
			if (rvalid_i) begin
				n++;
				rs &= rresp_i;
				{rid, last} = {rid_i, rlast_i};
			end
		end
		@(negedge clk_i);
		rready_o = 1'b0;
	endtask
endmodule // dslv_axi_mst

// file: tb_top.sv
// Purpose: self-checking bench for the default error-response slave
// Assumes: log depth 2, 40-bit addresses, register inputs not staged
// Notes: bench inputs change on the falling edge
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dslv_pkg::*;
	localparam int ID_W = 4;
	localparam int ADDR_W = 40;
	logic clk = 0, srst = 1, awv, awr, wl, wv, wr, bv, br, arv, arr, rl, rv, rr, cr = 0, cw = 0, irq;
	logic [ID_W-1:0] awid, bid, arid, rid;
	logic [ADDR_W-1:0] awa, ara;
	logic [3:0] awl, arl;
	logic [2:0] aws, awp, ars, arp;
	logic [1:0] awb, bresp, arb, rresp;
	logic [31:0] wd, rdat, cwd = '0, crd;
	logic [8:0] ca = '0;
	int errors = 0;
	int n_compared = 0;
	logic [ID_W-1:0] ids [3] = '{4'h5, 4'ha, 4'hf};
	logic [ADDR_W-1:0] adr [3] = '{40'h12_8765_4321, 40'hff_0000_0ffc, 40'h00_dead_0000};
	logic [11:0] fs [3] = '{12'h4d5, 12'h800, 12'h07f};
	dslv_default_slave #(.ID_W(ID_W), .ADDR_W(ADDR_W), .LOG_DEPTH(2)) uut (
		.SYS_CLK_I(clk), .SRST_I(srst), .AXI_AWID_I(awid), .AXI_AWADDR_I(awa), .AXI_AWLEN_I(awl),
		.AXI_AWSIZE_I(aws), .AXI_AWBURST_I(awb), .AXI_AWPROT_I(awp), .AXI_AWVALID_I(awv),
		.AXI_AWREADY_O(awr), .AXI_WDATA_I(wd), .AXI_WLAST_I(wl), .AXI_WVALID_I(wv),
		.AXI_WREADY_O(wr), .AXI_BID_O(bid), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bv),
		.AXI_BREADY_I(br), .AXI_ARID_I(arid), .AXI_ARADDR_I(ara), .AXI_ARLEN_I(arl),
		.AXI_ARSIZE_I(ars), .AXI_ARBURST_I(arb), .AXI_ARPROT_I(arp), .AXI_ARVALID_I(arv),
		.AXI_ARREADY_O(arr), .AXI_RID_O(rid), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rresp),
		.AXI_RLAST_O(rl), .AXI_RVALID_O(rv), .AXI_RREADY_I(rr), .CSR_ADDR_I(ca), .CSR_READ_I(cr),
		.CSR_WRITE_I(cw), .CSR_WDATA_I(cwd), .CSR_RDATA_O(crd), .IRQ_O(irq));
	dslv_axi_mst #(.ID_W(ID_W), .ADDR_W(ADDR_W)) m (
		.clk_i(clk), .awid_o(awid), .awaddr_o(awa), .awlen_o(awl), .awsize_o(aws), .awburst_o(awb),
		.awprot_o(awp), .awvalid_o(awv), .awready_i(awr), .wdata_o(wd), .wlast_o(wl),
		.wvalid_o(wv), .wready_i(wr), .bid_i(bid), .bresp_i(bresp), .bvalid_i(bv), .bready_o(br),
		.arid_o(arid), .araddr_o(ara), .arlen_o(arl), .arsize_o(ars), .arburst_o(arb),
		.arprot_o(arp), .arvalid_o(arv), .arready_i(arr), .rid_i(rid), .rresp_i(rresp),
		.rlast_i(rl), .rvalid_i(rv), .rready_o(rr));
	// 100 MHz clock
	initial forever #5 clk = ~clk;
	// compare and count
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	// register read, data taken one cycle after the strobe
	task automatic rc(input logic [8:0] a, input logic [31:0] exp);
		@(negedge clk);
		{ca, cr} = {a, 1'b1};
		@(negedge clk);
		cr = 1'b0;
		check(crd, exp);
	endtask
	// register write, one strobe cycle
	task automatic cwr(input logic [8:0] a, input logic [31:0] d);
		@(negedge clk);
		{ca, cwd, cw} = {a, d, 1'b1};
		@(negedge clk);
		cw = 1'b0;
	endtask
	task automatic conclude();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// hang guard, far beyond the hundred or so cycles the tests need
	initial begin
		#100us;
		errors++;
		conclude();
	end
	// test sequence
	initial begin
		logic [ID_W-1:0] id;
		logic [1:0] rs;
		logic [ID_W-1:0] wid;
		logic [1:0] wrs;
		int n;
		int k;
		repeat (8) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		// reset values, then an unmapped offset
		foreach (fs[i]) rc(OFS_RD_ATTR + 9'(i * 4), '0);
		rc(OFS_RD_ADDR_HIGH, '0);
		rc(9'h004, '0);
		check(irq, 1'b0);
		// three read violations into a two-entry log, prompt and slow master
		for (int i = 0; i < 3; i++) begin
			m.rd(ids[i], adr[i], fs[i], i, id, rs, n);
			check(n, fs[i][9:6] + 1);
			check(id, ids[i]);
			check(rs, RESP_DECERR);
			check(rdat, '0);
			rc(OFS_IRQ_STATUS, i < 2 ? 32'h2 : 32'ha);
			check(irq, 1'b1);
		end
		// writing zero and writing a read-only place change nothing
		cwr(OFS_IRQ_STATUS, '0);
		cwr(OFS_RD_ATTR, '1);
		rc(OFS_IRQ_STATUS, 32'ha);
		// host drains until the valid bit drops
		for (k = 0; k < 3; k++) begin
			rc(OFS_RD_ATTR, k < 2 ? {19'h0, fs[k], 1'b1} : '0);
			if (k == 2) break;
			rc(OFS_RD_MASTER_ID, 32'(ids[k]));
			rc(OFS_RD_ADDR_LOW, adr[k][31:0]);
			rc(OFS_RD_ADDR_HIGH, 32'(adr[k][39:32]));
		end
		check(k, 2);
		rc(OFS_IRQ_STATUS, 32'ha);
		// still logging while the flag stands, then cleared with its entry
		m.rd(ids[2], adr[2], fs[2], 0, id, rs, n);
		rc(OFS_RD_ATTR, {19'h0, fs[2], 1'b1});
		cwr(OFS_IRQ_STATUS, 32'h2);
		rc(OFS_RD_ATTR, '0);
		rc(OFS_IRQ_STATUS, 32'h8);
		cwr(OFS_IRQ_STATUS, 32'h8);
		rc(OFS_IRQ_STATUS, '0);
		check(irq, 1'b0);
		// read and write at once, then two more writes to overflow the count
		fork
			m.rd(ids[1], adr[1], fs[1], 2, id, rs, n);
			m.wr(ids[0], adr[0], fs[0], 1, wid, wrs);
		join
		check(id, ids[1]);
		check(wid, ids[0]);
		check(wrs, RESP_DECERR);
		for (int i = 1; i < 3; i++) begin
			m.wr(ids[i], adr[i], fs[i], 0, id, rs);
			check(id, ids[i]);
			check(rs, RESP_DECERR);
		end
		rc(OFS_IRQ_STATUS, 32'h7);
		rc(OFS_RD_MASTER_ID, 32'(ids[1]));
		cwr(OFS_IRQ_STATUS, 32'hf);
		rc(OFS_IRQ_STATUS, '0);
		check(irq, 1'b0);
		// after clearing a new write violation is counted again
		m.wr(ids[2], adr[2], fs[1], 0, id, rs);
		rc(OFS_IRQ_STATUS, 32'h1);
		conclude();
	end
endmodule // tb_top
